// *** logic/tfr_cfg.svh ***
`ifndef TFR_CFG_SVH
`define TFR_CFG_SVH

// Command codes
`define TFR_CODE_CLEAR_FAULTS 8'h03
`define TFR_CODE_OT_WARN      8'h51
`define TFR_CODE_UT_WARN      8'h52
`define TFR_CODE_UT_FAULT     8'h53
`define TFR_CODE_UT_ACTION    8'h54

// Reset values of the stored limits and action byte
`define TFR_RST_OT_WARN       16'h0000
`define TFR_RST_UT_WARN       16'h0000
`define TFR_RST_UT_FAULT      16'h0000
`define TFR_RST_UT_ACTION     8'h00

// Action byte field positions
`define TFR_ACT_RESP_HI       7
`define TFR_ACT_RESP_LO       6
`define TFR_ACT_RETRY_HI      5
`define TFR_ACT_RETRY_LO      3
`define TFR_ACT_DELAY_HI      2
`define TFR_ACT_DELAY_LO      0

// Linear format field positions
`define TFR_LIN_EXP_HI        15
`define TFR_LIN_EXP_LO        11
`define TFR_LIN_MANT_HI       10

// Retry setting meaning endless retries
`define TFR_RETRY_FOREVER     3'h7

`endif

// *** logic/tfr_pkg.sv ***
package tfr_pkg;

  // Response field of the action byte
  typedef enum logic [1:0] {
    TFR_RESP_IGNORE  = 2'h0,
    TFR_RESP_DELAY   = 2'h1,
    TFR_RESP_RETRY   = 2'h2,
    TFR_RESP_LATCH   = 2'h3
  } tfr_resp_t;

  // Fault response states, Gray in the listed order
  typedef enum logic [2:0] {
    TFR_ST_RUN   = 3'h0,
    TFR_ST_DELAY = 3'h1,
    TFR_ST_OFF   = 3'h3,
    TFR_ST_RETRY = 3'h2,
    TFR_ST_LATCH = 3'h6
  } tfr_state_t;

  // Command from the link
  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } tfr_req_t;

  // Answer to the link
  typedef struct packed {
    logic        ok;
    logic [15:0] rdata;
  } tfr_rsp_t;

endpackage

// *** logic/tfr_top.sv ***
`include "tfr_cfg.svh"

module tfr_top #(
  parameter int UNIT_W = 16
) (
  // Core clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Link side, own clock
  input  wire logic             lnk_clk,
  input  wire logic             lnk_req_valid,
  input  wire tfr_pkg::tfr_req_t lnk_req,
  output      logic             lnk_req_ready,
  output      logic             lnk_rsp_valid,
  output      tfr_pkg::tfr_rsp_t lnk_rsp,
  // Measurement and timing
  input  wire logic [15:0]      temp,
  input  wire logic [UNIT_W-1:0] unit_cycles,
  // Output control and clearing
  input  wire logic             ctrl_pin,
  input  wire logic             fault_rst_pin,
  input  wire logic             op_on,
  input  wire logic             clr_ut_flag,
  input  wire logic             other_fault_off,
  // Status and power stage control
  output      logic             out_en,
  output      logic             ut_fault_flag,
  output      logic             ut_warn,
  output      logic             ot_warn
);
  import tfr_pkg::*;

  // Linear word to a common fixed point value
  function automatic logic signed [47:0] tfr_lin(input logic [15:0] v);
    logic signed [47:0] m;
    logic [5:0]         sh;
    m  = 48'(signed'(v[`TFR_LIN_MANT_HI:0]));
    sh = 6'({v[`TFR_LIN_EXP_HI], v[`TFR_LIN_EXP_HI:`TFR_LIN_EXP_LO]}) + 6'h10;
    return m <<< sh;
  endfunction

  // ---------------- Link domain ----------------
  logic     l_tog_q;
  tfr_req_t l_hold_q;
  logic     l_ack_s1_q;
  logic     l_ack_s2_q;
  logic     l_ack_s3_q;
  logic     l_ack_seen_q;
  logic     c_ack_q;
  tfr_rsp_t c_rsp_q;

  // Ready while no request is in flight
  assign lnk_req_ready = (l_tog_q == l_ack_seen_q);

  // Capture a request and flag it by a toggle
  always_ff @(posedge lnk_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      l_tog_q  <= 1'b0;
      l_hold_q <= '0;
    end
    else if (lnk_req_valid && lnk_req_ready)
    begin
      l_tog_q  <= ~l_tog_q;
      l_hold_q <= lnk_req;
    end
  end

  // Answer toggle back into the link domain
  always_ff @(posedge lnk_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      l_ack_s1_q <= 1'b0;
      l_ack_s2_q <= 1'b0;
      l_ack_s3_q <= 1'b0;
    end
    else
    begin
      l_ack_s1_q <= c_ack_q;
      l_ack_s2_q <= l_ack_s1_q;
      l_ack_s3_q <= l_ack_s2_q;
    end
  end

  // Answer pulse, data held stable by the core
  always_ff @(posedge lnk_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      l_ack_seen_q  <= 1'b0;
      lnk_rsp_valid <= 1'b0;
      lnk_rsp       <= '0;
    end
    else if ((l_ack_s2_q == l_ack_s3_q) && (l_ack_s3_q != l_ack_seen_q))
    begin
      l_ack_seen_q  <= l_ack_s3_q;
      lnk_rsp_valid <= 1'b1;
      lnk_rsp       <= c_rsp_q;
    end
    else
      lnk_rsp_valid <= 1'b0;
  end

  // ---------------- Core domain ----------------
  logic        c_req_s1_q;
  logic        c_req_s2_q;
  logic        c_req_s3_q;
  logic        take;
  logic        hit;
  logic [15:0] rd_val;
  logic        clr_cmd_q;
  logic [15:0] ot_warn_lim_q;
  logic [15:0] ut_warn_lim_q;
  logic [15:0] ut_fault_lim_q;
  logic [7:0]  act_q;

  // Request toggle into the core domain
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c_req_s1_q <= 1'b0;
      c_req_s2_q <= 1'b0;
      c_req_s3_q <= 1'b0;
    end
    else
    begin
      c_req_s1_q <= l_tog_q;
      c_req_s2_q <= c_req_s1_q;
      c_req_s3_q <= c_req_s2_q;
    end
  end

  assign take = (c_req_s2_q == c_req_s3_q) && (c_req_s3_q != c_ack_q);

  // Command decode and read-back mux
  always_comb
  begin
    hit    = 1'b1;
    rd_val = 16'h0000;
    if (l_hold_q.code == `TFR_CODE_OT_WARN)
      rd_val = ot_warn_lim_q;
    else if (l_hold_q.code == `TFR_CODE_UT_WARN)
      rd_val = ut_warn_lim_q;
    else if (l_hold_q.code == `TFR_CODE_UT_FAULT)
      rd_val = ut_fault_lim_q;
    else if (l_hold_q.code == `TFR_CODE_UT_ACTION)
      rd_val = {8'h00, act_q};
    else if (l_hold_q.code == `TFR_CODE_CLEAR_FAULTS)
      hit = l_hold_q.write;
    else
      hit = 1'b0;
  end

  // Limit and action storage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ot_warn_lim_q  <= `TFR_RST_OT_WARN;
      ut_warn_lim_q  <= `TFR_RST_UT_WARN;
      ut_fault_lim_q <= `TFR_RST_UT_FAULT;
      act_q          <= `TFR_RST_UT_ACTION;
    end
    else if (take && l_hold_q.write)
    begin
      if (l_hold_q.code == `TFR_CODE_OT_WARN)
        ot_warn_lim_q <= l_hold_q.wdata;
      else if (l_hold_q.code == `TFR_CODE_UT_WARN)
        ut_warn_lim_q <= l_hold_q.wdata;
      else if (l_hold_q.code == `TFR_CODE_UT_FAULT)
        ut_fault_lim_q <= l_hold_q.wdata;
      else if (l_hold_q.code == `TFR_CODE_UT_ACTION)
        act_q <= l_hold_q.wdata[7:0];
    end
  end

  // Answer, clear command pulse, ack toggle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c_ack_q   <= 1'b0;
      c_rsp_q   <= '0;
      clr_cmd_q <= 1'b0;
    end
    else
    begin
      clr_cmd_q <= take && l_hold_q.write && (l_hold_q.code == `TFR_CODE_CLEAR_FAULTS);
      if (take)
      begin
        c_ack_q       <= ~c_ack_q;
        c_rsp_q.ok    <= hit;
        c_rsp_q.rdata <= l_hold_q.write ? 16'h0000 : rd_val;
      end
    end
  end

  // Pin inputs: three stages, accepted once stages two and three agree
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [1:0] pin_s3_q;
  logic [1:0] pin_f_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      pin_s3_q <= 2'h0;
      pin_f_q  <= 2'h0;
    end
    else
    begin
      pin_s1_q <= {fault_rst_pin, ctrl_pin};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q  <= (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q ^ pin_s3_q));
    end
  end

  // Fault and warning detection
  logic fault_det;
  logic cmd_on;
  logic cmd_on_q;
  logic clr_evt;

  assign fault_det = tfr_lin(temp) < tfr_lin(ut_fault_lim_q);
  assign cmd_on    = pin_f_q[0] && op_on;
  assign clr_evt   = clr_ut_flag || clr_cmd_q || pin_f_q[1] || (cmd_on && !cmd_on_q);

  // Warning levels and sticky fault flag, set beats clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ot_warn       <= 1'b0;
      ut_warn       <= 1'b0;
      ut_fault_flag <= 1'b0;
      cmd_on_q      <= 1'b0;
    end
    else
    begin
      ot_warn       <= tfr_lin(temp) > tfr_lin(ot_warn_lim_q);
      ut_warn       <= tfr_lin(temp) < tfr_lin(ut_warn_lim_q);
      ut_fault_flag <= fault_det || (ut_fault_flag && !clr_evt);
      cmd_on_q      <= cmd_on;
    end
  end

  // Delay timer in units of 2**n time units
  logic [UNIT_W-1:0] unit_cnt_q;
  logic [7:0]        units_q;
  logic              tick;
  logic              tmr_start;
  logic              tmr_done;
  logic [2:0]        dly_n;

  assign dly_n    = act_q[`TFR_ACT_DELAY_HI:`TFR_ACT_DELAY_LO];
  assign tick     = (unit_cnt_q + UNIT_W'(1)) >= unit_cycles;
  assign tmr_done = tick && (units_q == ((8'h01 << dly_n) - 8'h01));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      unit_cnt_q <= '0;
      units_q    <= 8'h00;
    end
    else if (tmr_start)
    begin
      unit_cnt_q <= '0;
      units_q    <= 8'h00;
    end
    else if (tick)
    begin
      unit_cnt_q <= '0;
      units_q    <= units_q + 8'h01;
    end
    else
      unit_cnt_q <= unit_cnt_q + UNIT_W'(1);
  end

  // Fault response state machine
  tfr_state_t state_q;
  tfr_state_t state_d;
  logic [2:0] rem_q;
  logic [2:0] rem_d;
  tfr_resp_t  resp;
  logic [2:0] retries;

  assign resp    = tfr_resp_t'(act_q[`TFR_ACT_RESP_HI:`TFR_ACT_RESP_LO]);
  assign retries = act_q[`TFR_ACT_RETRY_HI:`TFR_ACT_RETRY_LO];

  always_comb
  begin
    state_d   = state_q;
    rem_d     = rem_q;
    tmr_start = 1'b0;
    case (state_q)
      TFR_ST_RUN:
        if (fault_det)
        begin
          tmr_start = 1'b1;
          rem_d     = retries;
          case (resp)
            TFR_RESP_IGNORE: state_d = TFR_ST_RUN;
            TFR_RESP_DELAY:  state_d = TFR_ST_DELAY;
            TFR_RESP_RETRY:  state_d = (retries == 3'h0) ? TFR_ST_LATCH : TFR_ST_OFF;
            default:         state_d = TFR_ST_LATCH;
          endcase
        end
      TFR_ST_DELAY:
        if (tmr_done)
        begin
          tmr_start = 1'b1;
          if (!fault_det)
            state_d = TFR_ST_RUN;
          else
            state_d = (retries == 3'h0) ? TFR_ST_LATCH : TFR_ST_OFF;
        end
      TFR_ST_OFF:
        if (tmr_done)
        begin
          tmr_start = 1'b1;
          state_d   = TFR_ST_RETRY;
        end
      TFR_ST_RETRY:
        if (tmr_done)
        begin
          tmr_start = 1'b1;
          if (!fault_det)
            state_d = TFR_ST_RUN;
          else if (rem_q == `TFR_RETRY_FOREVER)
            state_d = TFR_ST_RETRY;
          else if (rem_q == 3'h1)
            state_d = TFR_ST_LATCH;
          else
            rem_d = rem_q - 3'h1;
        end
      default:
        state_d = TFR_ST_LATCH;
    endcase
    if (other_fault_off && (state_q == TFR_ST_RETRY))
      state_d = TFR_ST_LATCH;
    if (clr_evt)
      state_d = TFR_ST_RUN;
  end

  // State, retry budget and output enable registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= TFR_ST_RUN;
      rem_q   <= 3'h0;
      out_en  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      rem_q   <= rem_d;
      out_en  <= cmd_on && !other_fault_off && ((state_d == TFR_ST_RUN) ||
                 (state_d == TFR_ST_DELAY) || (state_d == TFR_ST_RETRY));
    end
  end

  // Checks
  property p_ot_store;
    @(posedge clk) disable iff (!rst_n)
    (take && l_hold_q.write && l_hold_q.code == `TFR_CODE_OT_WARN)
      |=> (ot_warn_lim_q == $past(l_hold_q.wdata));
  endproperty
  a_ot_store: assert property (p_ot_store) else $error("ot limit not stored");

  property p_utw_store;
    @(posedge clk) disable iff (!rst_n)
    (take && l_hold_q.write && l_hold_q.code == `TFR_CODE_UT_WARN)
      |=> (ut_warn_lim_q == $past(l_hold_q.wdata));
  endproperty
  a_utw_store: assert property (p_utw_store) else $error("ut warn not stored");

  property p_utf_store;
    @(posedge clk) disable iff (!rst_n)
    (take && l_hold_q.write && l_hold_q.code == `TFR_CODE_UT_FAULT)
      |=> (ut_fault_lim_q == $past(l_hold_q.wdata));
  endproperty
  a_utf_store: assert property (p_utf_store) else $error("ut fault not stored");

  property p_ignore;
    @(posedge clk) disable iff (!rst_n)
    (state_q == TFR_ST_RUN && resp == TFR_RESP_IGNORE) |=> (state_q == TFR_ST_RUN);
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignore mode left run");

  property p_delay;
    @(posedge clk) disable iff (!rst_n)
    (state_q == TFR_ST_RUN && resp == TFR_RESP_DELAY && fault_det && !clr_evt && cmd_on
     && !other_fault_off) |=> (state_q == TFR_ST_DELAY && out_en);
  endproperty
  a_delay: assert property (p_delay) else $error("delay mode not operating");

  property p_disable;
    @(posedge clk) disable iff (!rst_n)
    (state_q == TFR_ST_RUN && resp == TFR_RESP_RETRY && fault_det && !clr_evt) |=> !out_en;
  endproperty
  a_disable: assert property (p_disable) else $error("output not disabled");

  property p_latch_hold;
    @(posedge clk) disable iff (!rst_n)
    (state_q == TFR_ST_LATCH && !clr_evt) |=> (state_q == TFR_ST_LATCH && !out_en);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch released");

  property p_clear;
    @(posedge clk) disable iff (!rst_n)
    clr_evt |=> (state_q == TFR_ST_RUN);
  endproperty
  a_clear: assert property (p_clear) else $error("clear event ignored");

  property p_no_retry;
    @(posedge clk) disable iff (!rst_n)
    (state_q == TFR_ST_RUN && resp == TFR_RESP_RETRY && retries == 3'h0 && fault_det
     && !clr_evt) |=> (state_q == TFR_ST_LATCH);
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("restart with zero retries");

  property p_last_fail;
    @(posedge clk) disable iff (!rst_n)
    (state_q == TFR_ST_RETRY && tmr_done && fault_det && rem_q == 3'h1 && !clr_evt)
      |=> (state_q == TFR_ST_LATCH);
  endproperty
  a_last_fail: assert property (p_last_fail) else $error("no latch after last retry");

  property p_flag_set;
    @(posedge clk) disable iff (!rst_n)
    fault_det |=> ut_fault_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("fault flag not set");

endmodule

// *** tb/tfr_host_model.sv ***
module tfr_host_model (
  // Link
  input  wire logic              lnk_clk,
  input  wire logic              lnk_req_ready,
  output      logic              lnk_req_valid,
  output      tfr_pkg::tfr_req_t lnk_req
);
  timeunit 1ns;
  timeprecision 1ps;
  import tfr_pkg::*;

  // Idle link
  initial
  begin
    lnk_req_valid = 1'b0;
    lnk_req = '0;
  end

  // One request, held until taken, then answer awaited
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output bit late);
    int n;
    n = 0;
    @(negedge lnk_clk);
    lnk_req_valid = 1'b1;
    lnk_req = '{write: w, code: c, wdata: d};
    do
    begin
      @(posedge lnk_clk);
      n++;
    end
    while (lnk_req_ready !== 1'b1 && n < 50);
    late = (n >= 50);
    @(negedge lnk_clk);
    lnk_req_valid = 1'b0;
    // Released lines show no stale value
    lnk_req = ~lnk_req;
    n = 0;
    do
    begin
      @(posedge lnk_clk);
      n++;
    end
    while (lnk_req_ready !== 1'b1 && n < 50);
    late = late || (n >= 50);
  endtask
endmodule

// *** tb/test_temperature_fault_response.sv ***
module test_temperature_fault_response;
  timeunit 1ns;
  timeprecision 1ps;
  import tfr_pkg::*;

  logic        clk, rst_n, lnk_clk, lnk_req_valid, lnk_req_ready, lnk_rsp_valid;
  tfr_req_t    lnk_req;
  tfr_rsp_t    lnk_rsp;
  logic [15:0] temp, unit_cycles;
  logic        ctrl_pin, fault_rst_pin, op_on, clr_ut_flag, other_fault_off;
  logic        out_en, ut_fault_flag, ut_warn, ot_warn;
  int          bad_count = 0;
  int          samples_checked = 0;
  logic [16:0] exp_q[$];
  logic [31:0] lfsr;
  logic [7:0]  codes[4] = '{8'h51, 8'h52, 8'h53, 8'h54};

  // Clocks, unrelated in phase
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    lnk_clk = 1'b0;
    #7;
    forever #40 lnk_clk = ~lnk_clk;
  end

  tfr_top #(.UNIT_W(16)) DUT (
    .clk(clk), .rst_n(rst_n), .lnk_clk(lnk_clk), .lnk_req_valid(lnk_req_valid),
    .lnk_req(lnk_req), .lnk_req_ready(lnk_req_ready), .lnk_rsp_valid(lnk_rsp_valid),
    .lnk_rsp(lnk_rsp), .temp(temp), .unit_cycles(unit_cycles), .ctrl_pin(ctrl_pin),
    .fault_rst_pin(fault_rst_pin), .op_on(op_on), .clr_ut_flag(clr_ut_flag),
    .other_fault_off(other_fault_off), .out_en(out_en), .ut_fault_flag(ut_fault_flag),
    .ut_warn(ut_warn), .ot_warn(ot_warn));

  tfr_host_model host (
    .lnk_clk(lnk_clk), .lnk_req_ready(lnk_req_ready),
    .lnk_req_valid(lnk_req_valid), .lnk_req(lnk_req));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {16'h0, e}, {16'h0, g});
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Link request with its expected answer noted
  task automatic req(input logic w, input logic [7:0] c, input logic [15:0] d,
                     input logic [16:0] e);
    bit late;
    exp_q.push_back(e);
    host.xfer(w, c, d, late);
    if (late)
    begin
      bad_count++;
      complete_run();
    end
    @(negedge clk);
  endtask

  // Fault cleared by the individual flag clear
  task automatic clr_flag;
    clr_ut_flag = 1'b1;
    cyc(4);
    clr_ut_flag = 1'b0;
  endtask

  // Cycles with the output enabled inside a window
  task automatic count_high(input int win, output int h);
    h = 0;
    repeat (win)
    begin
      @(negedge clk);
      if (out_en === 1'b1)
        h++;
    end
  endtask

  // Answer watcher takes the oldest note, mid-cycle where the answer stands
  always @(negedge lnk_clk)
    if (lnk_rsp_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        bad_count++;
        $display("CHECK FAILED unexpected answer expected none seen %h", lnk_rsp);
      end
      else
        chk("lnk_rsp", exp_q.pop_front(), lnk_rsp);
    end

  // Hang guard
  initial
  begin
    #2000000;
    bad_count++;
    complete_run();
  end

  // Main sequence
  initial
  begin
    logic [15:0] d;
    int r;
    rst_n = 1'b0;
    temp = 16'h0019;
    unit_cycles = 16'h0003;
    ctrl_pin = 1'b1;
    fault_rst_pin = 1'b0;
    op_on = 1'b1;
    clr_ut_flag = 1'b0;
    other_fault_off = 1'b0;
    lfsr = 32'hbf65c3a0;
    repeat (2) @(negedge lnk_clk);
    @(negedge clk);
    rst_n = 1'b1;
    cyc(8);
    chk1("out_en", 1'b1, out_en);
    // Reset values, random write, read back
    for (int i = 0; i < 4; i++)
    begin
      lfsr = lfsr_next(lfsr);
      d = (i == 3) ? {8'h00, lfsr[7:0]} : lfsr[15:0];
      req(1'b0, codes[i], 16'h0, 17'h10000);
      req(1'b1, codes[i], lfsr[15:0], 17'h10000);
      req(1'b0, codes[i], 16'h0, {1'b1, d});
    end
    req(1'b0, 8'h77, 16'h0, 17'h0);
    req(1'b0, 8'h03, 16'h0, 17'h0);
    // Limits: over 80, under -10, fault -20, ignore faults
    req(1'b1, 8'h51, 16'h0050, 17'h10000);
    req(1'b1, 8'h52, 16'h07f6, 17'h10000);
    req(1'b1, 8'h53, 16'h07ec, 17'h10000);
    req(1'b1, 8'h54, 16'h0000, 17'h10000);
    req(1'b1, 8'h03, 16'h0000, 17'h10000);
    clr_flag();
    cyc(8);
    chk1("out_en", 1'b1, out_en);
    chk1("ut_fault_flag", 1'b0, ut_fault_flag);
    temp = 16'h0064;
    cyc(3);
    chk1("ot_warn", 1'b1, ot_warn);
    chk1("ut_warn", 1'b0, ut_warn);
    temp = 16'h07f1;
    cyc(3);
    chk1("ot_warn", 1'b0, ot_warn);
    chk1("ut_warn", 1'b1, ut_warn);
    chk1("ut_fault_flag", 1'b0, ut_fault_flag);
    // Ignore response
    temp = 16'h07e2;
    cyc(20);
    chk1("out_en", 1'b1, out_en);
    chk1("ut_fault_flag", 1'b1, ut_fault_flag);
    temp = 16'h0019;
    clr_flag();
    cyc(2);
    chk1("ut_fault_flag", 1'b0, ut_fault_flag);
    // Latch off, each clearing event
    req(1'b1, 8'h54, 16'h00c0, 17'h10000);
    for (int m = 0; m < 4; m++)
    begin
      temp = 16'h07e2;
      cyc(3);
      chk1("out_en", 1'b0, out_en);
      temp = 16'h0019;
      cyc(20);
      chk1("out_en", 1'b0, out_en);
      case (m)
        0: clr_flag();
        1: req(1'b1, 8'h03, 16'h0000, 17'h10000);
        2:
        begin
          fault_rst_pin = 1'b1;
          cyc(5);
          fault_rst_pin = 1'b0;
        end
        default:
        begin
          op_on = 1'b0;
          cyc(5);
          op_on = 1'b1;
        end
      endcase
      cyc(8);
      chk1("out_en", 1'b1, out_en);
    end
    // Disable and retry, delay 6 cycles, every retry setting
    for (int k = 0; k < 8; k++)
    begin
      req(1'b1, 8'h54, {8'h00, 2'b10, 3'(k), 3'b001}, 17'h10000);
      temp = 16'h07e2;
      cyc(2);
      chk1("out_en", 1'b0, out_en);
      // Attempts follow back to back, each keeps the output on one interval
      count_high(150, r);
      if (k < 7)
      begin
        chk("attempts", 17'(k * 6), 17'(r));
        chk1("out_en", 1'b0, out_en);
      end
      else
      begin
        chk1("endless", 1'b1, r >= 140);
        chk1("out_en", 1'b1, out_en);
        other_fault_off = 1'b1;
        cyc(2);
        count_high(60, r);
        chk("attempts", 17'h0, 17'(r));
        other_fault_off = 1'b0;
      end
      temp = 16'h0019;
      clr_flag();
      cyc(8);
    end
    // Operate for the delay, every delay code
    for (int n = 0; n < 8; n++)
    begin
      req(1'b1, 8'h54, {8'h00, 2'b01, 3'b000, 3'(n)}, 17'h10000);
      temp = 16'h07e2;
      cyc((3 << n) - 2);
      chk1("out_en", 1'b1, out_en);
      cyc(5);
      chk1("out_en", 1'b0, out_en);
      temp = 16'h0019;
      clr_flag();
      cyc(8);
    end
    cyc(20);
    chk("pending", 17'h0, 17'(exp_q.size()));
    complete_run();
  end
endmodule
